// File: rtl/txf_consts.vh
`ifndef TXF_CONSTS_VH
`define TXF_CONSTS_VH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define TXF_ADDR_SLOW_MASK 8'hBA
`define TXF_ADDR_FAST_MASK 8'hBB
`define TXF_ADDR_PWR_HIGH_MARGIN 8'hBC
`define TXF_ADDR_PWR_LOW_MARGIN 8'hBD
`define TXF_ADDR_BIAS_HIGH_THR 8'hBE
`define TXF_ADDR_BIAS_CEILING 8'hBF
`define TXF_REG_COUNT 6

// ------------------------------------------------------------
// register indices inside the bank
// ------------------------------------------------------------
`define TXF_IDX_SLOW_MASK 3'h0
`define TXF_IDX_FAST_MASK 3'h1
`define TXF_IDX_PWR_HIGH_MARGIN 3'h2
`define TXF_IDX_PWR_LOW_MARGIN 3'h3
`define TXF_IDX_BIAS_HIGH_THR 3'h4
`define TXF_IDX_BIAS_CEILING 3'h5

// ------------------------------------------------------------
// reset values and writable bit masks
// ------------------------------------------------------------
`define TXF_RESET_VALUE 8'h00
`define TXF_SLOW_MASK_WRITABLE 8'hFC
`define TXF_FAST_MASK_WRITABLE 8'hF1
`define TXF_FULL_WRITABLE 8'hFF

// ------------------------------------------------------------
// field positions, slow mask
// ------------------------------------------------------------
`define TXF_BIT_TEMP_EN 7
`define TXF_BIT_VCC_EN 6
`define TXF_BIT_MON_ONE_EN 5
`define TXF_BIT_MON_TWO_EN 4
`define TXF_BIT_MON_THREE_EN 3
`define TXF_BIT_MON_FOUR_EN 2

// ------------------------------------------------------------
// field positions, fast mask
// ------------------------------------------------------------
`define TXF_BIT_PWR_HIGH_EN 7
`define TXF_BIT_PWR_LOW_EN 6
`define TXF_BIT_BIAS_HIGH_EN 5
`define TXF_BIT_BIAS_CEIL_EN 4
`define TXF_BIT_GATE_CHAIN_EN 0

// ------------------------------------------------------------
// codes
// ------------------------------------------------------------
`define TXF_CODE_MAX 8'hFF
`define TXF_CODE_MIN 8'h00
`define TXF_BIAS_LOW_FILL 5'h1F

`endif

// File: rtl/txf_reg_bank.v
`timescale 1ns/1ps
`default_nettype none
`include "txf_consts.vh"

module txf_reg_bank (
  input wire clock_i,
  input wire reset_i,
  input wire enable_i,
  input wire [7:0] addr_i,
  input wire wr_i,
  input wire [7:0] wr_data_i,
  input wire rd_i,
  output reg [7:0] rd_data_o,
  output wire [8*`TXF_REG_COUNT-1:0] regs_o
);

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  function [3:0] decode_index;
    input [7:0] addr;
    begin
      if (addr == `TXF_ADDR_SLOW_MASK) begin
        decode_index = {1'b1, `TXF_IDX_SLOW_MASK};
      end else if (addr == `TXF_ADDR_FAST_MASK) begin
        decode_index = {1'b1, `TXF_IDX_FAST_MASK};
      end else if (addr == `TXF_ADDR_PWR_HIGH_MARGIN) begin
        decode_index = {1'b1, `TXF_IDX_PWR_HIGH_MARGIN};
      end else if (addr == `TXF_ADDR_PWR_LOW_MARGIN) begin
        decode_index = {1'b1, `TXF_IDX_PWR_LOW_MARGIN};
      end else if (addr == `TXF_ADDR_BIAS_HIGH_THR) begin
        decode_index = {1'b1, `TXF_IDX_BIAS_HIGH_THR};
      end else if (addr == `TXF_ADDR_BIAS_CEILING) begin
        decode_index = {1'b1, `TXF_IDX_BIAS_CEILING};
      end else begin
        decode_index = 4'h0;
      end
    end
  endfunction

  // reserved bits are never stored, so they read as zero
  function [7:0] writable;
    input [2:0] idx;
    begin
      if (idx == `TXF_IDX_SLOW_MASK) begin
        writable = `TXF_SLOW_MASK_WRITABLE;
      end else if (idx == `TXF_IDX_FAST_MASK) begin
        writable = `TXF_FAST_MASK_WRITABLE;
      end else begin
        writable = `TXF_FULL_WRITABLE;
      end
    end
  endfunction

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  reg [7:0] mem_r [0:`TXF_REG_COUNT-1];
  wire [3:0] hit = decode_index(addr_i);
  integer i;

  always @(posedge clock_i) begin
    if (reset_i) begin
      for (i = 0; i < `TXF_REG_COUNT; i = i + 1) begin
        mem_r[i] <= `TXF_RESET_VALUE;
      end
      rd_data_o <= `TXF_RESET_VALUE;
    end else if (enable_i) begin
      if (wr_i && hit[3]) begin
        mem_r[hit[2:0]] <= wr_data_i & writable(hit[2:0]);
      end
      if (rd_i) begin
        rd_data_o <= hit[3] ? mem_r[hit[2:0]] : `TXF_CODE_MIN;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `TXF_REG_COUNT; g = g + 1) begin : flat
      assign regs_o[8*g +: 8] = mem_r[g];
    end
  endgenerate

endmodule
`default_nettype wire

// File: rtl/txf_threshold_calc.v
`timescale 1ns/1ps
`default_nettype none
`include "txf_consts.vh"

module txf_threshold_calc (
  input wire clock_i,
  input wire reset_i,
  input wire enable_i,
  input wire [7:0] power_loop_setpoint_i,
  input wire [7:0] power_high_margin_i,
  input wire [7:0] power_low_margin_i,
  output reg [7:0] high_code_o,
  output reg [7:0] low_code_o
);

  // ------------------------------------------------------------
  // saturating arithmetic
  // ------------------------------------------------------------
  wire [8:0] sum = {1'b0, power_loop_setpoint_i} + {1'b0, power_high_margin_i};
  wire [8:0] diff = {1'b0, power_loop_setpoint_i} - {1'b0, power_low_margin_i};

  always @(posedge clock_i) begin
    if (reset_i) begin
      high_code_o <= `TXF_CODE_MIN;
      low_code_o <= `TXF_CODE_MIN;
    end else if (enable_i) begin
      high_code_o <= sum[8] ? `TXF_CODE_MAX : sum[7:0];
      low_code_o <= diff[8] ? `TXF_CODE_MIN : diff[7:0];
    end
  end

endmodule
`default_nettype wire

// File: rtl/txf_fault_gate.v
`timescale 1ns/1ps
`default_nettype none
`include "txf_consts.vh"

module txf_fault_gate #(
  parameter BIAS_WIDTH = 13
) (
  input wire clock_i,
  input wire reset_i,
  input wire enable_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wr_data_i,
  input wire reg_rd_i,
  output wire [7:0] reg_rd_data_o,
  input wire temp_alarm_i,
  input wire vcc_alarm_i,
  input wire [3:0] monitor_alarm_i,
  input wire [7:0] power_loop_setpoint_i,
  input wire [7:0] monitor_diode_voltage_i,
  input wire [7:0] bias_monitor_input_i,
  input wire [BIAS_WIDTH-1:0] bias_request_i,
  input wire fast_shutdown_gate_i,
  output reg [BIAS_WIDTH-1:0] bias_dac_o,
  output reg power_high_alarm_o,
  output reg power_low_alarm_o,
  output reg bias_high_alarm_o,
  output reg bias_ceiling_alarm_o,
  output wire [7:0] power_high_code_o,
  output wire [7:0] power_low_code_o,
  output reg tx_fault_o
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  localparam LOW_BITS = BIAS_WIDTH - 8;

  function greater;
    input [7:0] a;
    input [7:0] b;
    begin
      greater = (a > b);
    end
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  reg [7:0] diode_meta_r;
  reg [7:0] diode_sync_r;
  reg [7:0] bias_mon_meta_r;
  reg [7:0] bias_mon_sync_r;
  reg gate_meta_r;
  reg gate_sync_r;

  always @(posedge clock_i) begin
    if (reset_i) begin
      diode_meta_r <= 8'h00;
      diode_sync_r <= 8'h00;
      bias_mon_meta_r <= 8'h00;
      bias_mon_sync_r <= 8'h00;
      gate_meta_r <= 1'b0;
      gate_sync_r <= 1'b0;
    end else if (enable_i) begin
      diode_meta_r <= monitor_diode_voltage_i;
      diode_sync_r <= diode_meta_r;
      bias_mon_meta_r <= bias_monitor_input_i;
      bias_mon_sync_r <= bias_mon_meta_r;
      gate_meta_r <= fast_shutdown_gate_i;
      gate_sync_r <= gate_meta_r;
    end
  end

  // ------------------------------------------------------------
  // register bank
  // ------------------------------------------------------------
  wire [8*`TXF_REG_COUNT-1:0] regs;

  txf_reg_bank bank (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .enable_i(enable_i),
    .addr_i(reg_addr_i),
    .wr_i(reg_wr_i),
    .wr_data_i(reg_wr_data_i),
    .rd_i(reg_rd_i),
    .rd_data_o(reg_rd_data_o),
    .regs_o(regs)
  );

  wire [7:0] slow_mask = regs[8*`TXF_IDX_SLOW_MASK +: 8];
  wire [7:0] fast_mask = regs[8*`TXF_IDX_FAST_MASK +: 8];
  wire [7:0] power_high_margin = regs[8*`TXF_IDX_PWR_HIGH_MARGIN +: 8];
  wire [7:0] power_low_margin = regs[8*`TXF_IDX_PWR_LOW_MARGIN +: 8];
  wire [7:0] bias_high_threshold = regs[8*`TXF_IDX_BIAS_HIGH_THR +: 8];
  wire [7:0] bias_dac_ceiling = regs[8*`TXF_IDX_BIAS_CEILING +: 8];

  wire temp_fault_enable = slow_mask[`TXF_BIT_TEMP_EN];
  wire vcc_fault_enable = slow_mask[`TXF_BIT_VCC_EN];
  wire monitor_one_fault_enable = slow_mask[`TXF_BIT_MON_ONE_EN];
  wire monitor_two_fault_enable = slow_mask[`TXF_BIT_MON_TWO_EN];
  wire monitor_three_fault_enable = slow_mask[`TXF_BIT_MON_THREE_EN];
  wire monitor_four_fault_enable = slow_mask[`TXF_BIT_MON_FOUR_EN];
  wire power_high_fault_enable = fast_mask[`TXF_BIT_PWR_HIGH_EN];
  wire power_low_fault_enable = fast_mask[`TXF_BIT_PWR_LOW_EN];
  wire bias_high_fault_enable = fast_mask[`TXF_BIT_BIAS_HIGH_EN];
  wire bias_ceiling_fault_enable = fast_mask[`TXF_BIT_BIAS_CEIL_EN];
  wire shutdown_gate_chain_enable = fast_mask[`TXF_BIT_GATE_CHAIN_EN];

  // ------------------------------------------------------------
  // power thresholds
  // ------------------------------------------------------------
  // margins share the setpoint scale, so plain code arithmetic is valid
  txf_threshold_calc thresholds (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .enable_i(enable_i),
    .power_loop_setpoint_i(power_loop_setpoint_i),
    .power_high_margin_i(power_high_margin),
    .power_low_margin_i(power_low_margin),
    .high_code_o(power_high_code_o),
    .low_code_o(power_low_code_o)
  );

  // ------------------------------------------------------------
  // bias ceiling clamp
  // ------------------------------------------------------------
  wire [7:0] bias_request_upper = bias_request_i[BIAS_WIDTH-1:LOW_BITS];
  wire bias_over_ceiling = greater(bias_request_upper, bias_dac_ceiling);
  wire [BIAS_WIDTH-1:0] bias_clamped = {bias_dac_ceiling, {LOW_BITS{1'b1}}};

  always @(posedge clock_i) begin
    if (reset_i) begin
      bias_dac_o <= {BIAS_WIDTH{1'b0}};
    end else if (enable_i) begin
      // over the ceiling the output sits at the top of the ceiling step
      bias_dac_o <= bias_over_ceiling ? bias_clamped : bias_request_i;
    end
  end

  // ------------------------------------------------------------
  // fast comparators
  // ------------------------------------------------------------
  always @(posedge clock_i) begin
    if (reset_i) begin
      power_high_alarm_o <= 1'b0;
      power_low_alarm_o <= 1'b0;
      bias_high_alarm_o <= 1'b0;
      bias_ceiling_alarm_o <= 1'b0;
    end else if (enable_i) begin
      power_high_alarm_o <= greater(diode_sync_r, power_high_code_o);
      power_low_alarm_o <= greater(power_low_code_o, diode_sync_r);
      bias_high_alarm_o <= greater(bias_mon_sync_r, bias_high_threshold);
      bias_ceiling_alarm_o <= bias_over_ceiling;
    end
  end

  // ------------------------------------------------------------
  // fault aggregation
  // ------------------------------------------------------------
  reg slow_fault;
  reg fast_fault;
  reg gate_fault;

  always @* begin
    slow_fault = 1'b0;
    fast_fault = 1'b0;
    gate_fault = 1'b0;
    if (temp_fault_enable && temp_alarm_i) begin
      slow_fault = 1'b1;
    end
    if (vcc_fault_enable && vcc_alarm_i) begin
      slow_fault = 1'b1;
    end
    if (monitor_one_fault_enable && monitor_alarm_i[0]) begin
      slow_fault = 1'b1;
    end
    if (monitor_two_fault_enable && monitor_alarm_i[1]) begin
      slow_fault = 1'b1;
    end
    if (monitor_three_fault_enable && monitor_alarm_i[2]) begin
      slow_fault = 1'b1;
    end
    if (monitor_four_fault_enable && monitor_alarm_i[3]) begin
      slow_fault = 1'b1;
    end
    if (power_high_fault_enable && power_high_alarm_o) begin
      fast_fault = 1'b1;
    end
    if (power_low_fault_enable && power_low_alarm_o) begin
      fast_fault = 1'b1;
    end
    if (bias_high_fault_enable && bias_high_alarm_o) begin
      fast_fault = 1'b1;
    end
    if (bias_ceiling_fault_enable && bias_ceiling_alarm_o) begin
      fast_fault = 1'b1;
    end
    if (shutdown_gate_chain_enable && gate_sync_r) begin
      gate_fault = 1'b1;
    end
  end

  always @(posedge clock_i) begin
    if (reset_i) begin
      tx_fault_o <= 1'b0;
    end else if (enable_i) begin
      tx_fault_o <= slow_fault | fast_fault | gate_fault;
    end
  end

endmodule
`default_nettype wire

// File: dv/laser_side_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// laser driver side: drives the monitor pins one edge late
// ------------------------------------------------------------
module laser_side_model (
  input wire logic clock_i,
  input wire logic [7:0] diode_i,
  input wire logic [7:0] bias_i,
  input wire logic gate_i,
  output logic [7:0] diode_o,
  output logic [7:0] bias_o,
  output logic gate_o
);
  initial begin
    diode_o = 8'h00;
    bias_o = 8'h00;
    gate_o = 1'b0;
  end
  always @(posedge clock_i) begin
    diode_o <= diode_i;
    bias_o <= bias_i;
    gate_o <= gate_i;
  end
endmodule
`default_nettype wire

// File: dv/txf_fault_gate_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "txf_consts.vh"
// ------------------------------------------------------------
// port checks of the fault gate
// ------------------------------------------------------------
module txf_fault_gate_checker #(
  parameter BIAS_WIDTH = 13
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rd_data_o,
  input wire logic temp_alarm_i,
  input wire logic vcc_alarm_i,
  input wire logic [3:0] monitor_alarm_i,
  input wire logic [7:0] monitor_diode_voltage_i,
  input wire logic [BIAS_WIDTH-1:0] bias_request_i,
  input wire logic fast_shutdown_gate_i,
  input wire logic [BIAS_WIDTH-1:0] bias_dac_o,
  input wire logic power_high_alarm_o,
  input wire logic power_low_alarm_o,
  input wire logic bias_high_alarm_o,
  input wire logic bias_ceiling_alarm_o,
  input wire logic [7:0] power_high_code_o,
  input wire logic [7:0] power_low_code_o,
  input wire logic tx_fault_o
);
  logic [2:0] settle_r;
  wire ok = settle_r == 3'h4;
  wire rd_en = reg_rd_i && enable_i;
  wire [7:0] req_top = bias_request_i[BIAS_WIDTH-1:5];
  wire any_src = temp_alarm_i || vcc_alarm_i || (|monitor_alarm_i) || power_high_alarm_o
    || power_low_alarm_o || bias_high_alarm_o || bias_ceiling_alarm_o;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);
  // history of the pipeline is valid only after four free-running edges
  always @(posedge clock_i) begin
    if (reset_i || !enable_i) settle_r <= 3'h0;
    else if (!ok) settle_r <= settle_r + 3'h1;
  end
  property p_reset; disable iff (1'b0) reset_i && enable_i |=> !tx_fault_o
    && bias_dac_o == '0 && reg_rd_data_o == 8'h00 && !power_high_alarm_o; endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  property p_high; ok |-> power_high_alarm_o ==
    ($past(monitor_diode_voltage_i, 3) > $past(power_high_code_o)); endproperty
  a_high: assert property (p_high) else $error("power high alarm wrong");
  property p_low; ok |-> power_low_alarm_o ==
    ($past(monitor_diode_voltage_i, 3) < $past(power_low_code_o)); endproperty
  a_low: assert property (p_low) else $error("power low alarm wrong");
  property p_fault; ok && tx_fault_o |-> $past(any_src) || $past(fast_shutdown_gate_i, 3);
  endproperty
  a_fault: assert property (p_fault) else $error("fault without a source");
  property p_pass; ok && !bias_ceiling_alarm_o |-> bias_dac_o == $past(bias_request_i);
  endproperty
  a_pass: assert property (p_pass) else $error("bias not passed through");
  property p_clamp; ok && bias_ceiling_alarm_o |-> bias_dac_o[4:0] == 5'h1F
    && bias_dac_o[BIAS_WIDTH-1:5] < $past(req_top); endproperty
  a_clamp: assert property (p_clamp) else $error("bias clamp wrong");
  property p_unmap; rd_en && (reg_addr_i < `TXF_ADDR_SLOW_MASK
    || reg_addr_i > `TXF_ADDR_BIAS_CEILING) |=> reg_rd_data_o == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_resv; rd_en && reg_addr_i == `TXF_ADDR_FAST_MASK |=> reg_rd_data_o[3:1] == 3'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits read set");
  property p_hold; !rd_en |=> $stable(reg_rd_data_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_freeze; !enable_i |=> $stable(tx_fault_o) && $stable(bias_dac_o)
    && $stable(reg_rd_data_o); endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
  c_fault: cover property ($rose(tx_fault_o));
  c_clamp: cover property (bias_ceiling_alarm_o);
  c_low: cover property (power_low_alarm_o);
endmodule
bind txf_fault_gate txf_fault_gate_checker #(.BIAS_WIDTH(BIAS_WIDTH)) u_chk (.*);
`default_nettype wire

// File: dv/transmit_fault_mask_and_fast_thresholds_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "txf_consts.vh"
module transmit_fault_mask_and_fast_thresholds_test;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic wr = 1'b0, rd = 1'b0, temp = 1'b0, vcc = 1'b0, gate = 1'b0, en = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, setp = 8'h00, diode = 8'h00, bmon = 8'h00;
  logic [3:0] mon = 4'h0;
  logic [12:0] breq = 13'h0000;
  wire [7:0] rdata, dpin, bpin, hcode, lcode;
  wire [12:0] dac;
  wire gpin, phi, plo, bhi, bcl, fault;
  int n_fail = 0;
  int samples_checked = 0;
  always #10 clock_i = ~clock_i;
  laser_side_model u_far (.clock_i(clock_i), .diode_i(diode), .bias_i(bmon), .gate_i(gate),
    .diode_o(dpin), .bias_o(bpin), .gate_o(gpin));
  txf_fault_gate #(.BIAS_WIDTH(13)) u_dut (.clock_i(clock_i), .reset_i(reset_i),
    .enable_i(en), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wr_data_i(wdata), .reg_rd_i(rd),
    .reg_rd_data_o(rdata), .temp_alarm_i(temp), .vcc_alarm_i(vcc), .monitor_alarm_i(mon),
    .power_loop_setpoint_i(setp), .monitor_diode_voltage_i(dpin),
    .bias_monitor_input_i(bpin), .bias_request_i(breq), .fast_shutdown_gate_i(gpin),
    .bias_dac_o(dac), .power_high_alarm_o(phi), .power_low_alarm_o(plo),
    .bias_high_alarm_o(bhi), .bias_ceiling_alarm_o(bcl), .power_high_code_o(hcode),
    .power_low_code_o(lcode), .tx_fault_o(fault));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(string name, logic [12:0] exp, logic [12:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [7:0] a, logic [7:0] exp);
    @(posedge clock_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1 chk("rd_data", 13'(exp), 13'(rdata));
  endtask
  task automatic fault_is(logic exp);
    tick(7);
    chk("tx_fault", 13'(exp), 13'(fault));
  endtask
  task automatic set_slow(logic [7:0] v);
    @(posedge clock_i);
    temp <= v[7];
    vcc <= v[6];
    mon <= {v[2], v[3], v[4], v[5]};
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    int a;
    for (a = 8'hBA; a <= 8'hC0; a++) rd_reg(a[7:0], 8'h00);
    wr_reg(8'hBA, 8'hFF);
    rd_reg(8'hBA, 8'hFC);
    wr_reg(8'hBB, 8'hFF);
    rd_reg(8'hBB, 8'hF1);
    for (a = 8'hBC; a <= 8'hC0; a++) begin
      wr_reg(a[7:0], a[7:0] ^ 8'h5A);
      rd_reg(a[7:0], (a == 8'hC0) ? 8'h00 : a[7:0] ^ 8'h5A);
    end
    rd_reg(8'hBA, 8'hFC);
    wr_reg(8'hBB, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_slow();
    int b;
    for (b = 7; b >= 2; b--) begin
      wr_reg(8'hBA, 8'h01 << b);
      set_slow(8'h01 << b);
      fault_is(1'b1);
      set_slow(8'hFC ^ (8'h01 << b));
      fault_is(1'b0);
    end
    set_slow(8'h00);
    wr_reg(8'hBA, 8'h00);
    $display("t_slow done");
  endtask
  task automatic code_case(logic [7:0] s, logic [7:0] h, logic [7:0] l);
    logic [8:0] sum;
    sum = {1'b0, s} + {1'b0, h};
    wr_reg(8'hBC, h);
    wr_reg(8'hBD, l);
    @(posedge clock_i);
    setp <= s;
    tick(3);
    chk("high_code", 13'(sum[8] ? 8'hFF : sum[7:0]), 13'(hcode));
    chk("low_code", 13'((s < l) ? 8'h00 : s - l), 13'(lcode));
  endtask
  task automatic pwr_case(logic [7:0] m, logic [7:0] d);
    wr_reg(8'hBB, m);
    @(posedge clock_i);
    diode <= d;
    fault_is((m[7] && d > 8'h90) || (m[6] && d < 8'h70));
    chk("power_high", 13'(d > 8'h90), 13'(phi));
    chk("power_low", 13'(d < 8'h70), 13'(plo));
  endtask
  task automatic bias_case(logic [7:0] m, logic [7:0] bm, logic [12:0] req);
    logic cl;
    cl = req[12:5] > 8'h20;
    wr_reg(8'hBB, m);
    @(posedge clock_i);
    bmon <= bm;
    breq <= req;
    fault_is((m[5] && bm > 8'h40) || (m[4] && cl));
    chk("bias_dac", cl ? {8'h20, 5'h1F} : req, dac);
    chk("bias_ceiling", 13'(cl), 13'(bcl));
    chk("bias_high", 13'(bm > 8'h40), 13'(bhi));
  endtask
  task automatic t_fast();
    code_case(8'hF0, 8'h20, 8'h20);
    code_case(8'h10, 8'h05, 8'h20);
    code_case(8'h81, 8'h7F, 8'h81);
    code_case(8'h80, 8'h10, 8'h10);
    pwr_case(8'hC0, 8'h91);
    pwr_case(8'hC0, 8'h90);
    pwr_case(8'hC0, 8'h6F);
    pwr_case(8'hC0, 8'h70);
    pwr_case(8'h40, 8'h91);
    pwr_case(8'h00, 8'h80);
    wr_reg(8'hBE, 8'h40);
    wr_reg(8'hBF, 8'h20);
    bias_case(8'h30, 8'h41, 13'h041F);
    bias_case(8'h30, 8'h40, 13'h0420);
    bias_case(8'h10, 8'h41, 13'h1FFF);
    bias_case(8'h20, 8'h00, 13'h0420);
    bias_case(8'h00, 8'h00, 13'h0000);
    $display("t_fast done");
  endtask
  task automatic t_gate();
    wr_reg(8'hBB, 8'h00);
    @(posedge clock_i);
    gate <= 1'b1;
    fault_is(1'b0);
    wr_reg(8'hBB, 8'h01);
    fault_is(1'b1);
    @(posedge clock_i);
    gate <= 1'b0;
    fault_is(1'b0);
    $display("t_gate done");
  endtask
  task automatic t_freeze();
    wr_reg(8'hBA, 8'h80);
    @(posedge clock_i);
    en <= 1'b0;
    temp <= 1'b1;
    wr_reg(8'hBA, 8'h00);
    tick(3);
    chk("frozen_fault", 13'h0000, 13'(fault));
    @(posedge clock_i);
    en <= 1'b1;
    fault_is(1'b1);
    rd_reg(8'hBA, 8'h80);
    set_slow(8'h00);
    wr_reg(8'hBA, 8'h00);
    $display("t_freeze done");
  endtask
  task automatic t_rerun();
    wr_reg(8'hBA, 8'h80);
    set_slow(8'h80);
    fault_is(1'b1);
    @(posedge clock_i);
    reset_i <= 1'b1;
    repeat (16) @(posedge clock_i);
    reset_i <= 1'b0;
    fault_is(1'b0);
    rd_reg(8'hBA, 8'h00);
    set_slow(8'h00);
    $display("t_rerun done");
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clock_i);
    reset_i <= 1'b0;
    t_regs();
    t_slow();
    t_fast();
    t_gate();
    t_freeze();
    t_rerun();
    stop_test();
  end
endmodule
`default_nettype wire
